//--- core/stmr_cfg.svh
`ifndef STMR_CFG_SVH
`define STMR_CFG_SVH
// register byte offsets on the wishbone bus
`define STMR_OFS_CTL0   8'h00
`define STMR_OFS_CTL1   8'h04
`define STMR_OFS_CNTL   8'h08
`define STMR_OFS_CNTH   8'h0c
`define STMR_OFS_CMPAL  8'h10
`define STMR_OFS_CMPAH  8'h14
// control zero fields
`define STMR_PAUSE_BIT  7
`define STMR_CKSEL_HI   6
`define STMR_CKSEL_LO   4
`define STMR_ON_BIT     3
`define STMR_PER_HI     2
`define STMR_PER_LO     0
// control one fields
`define STMR_MODE_HI    7
`define STMR_MODE_LO    6
`define STMR_OFUNC_HI   5
`define STMR_OFUNC_LO   4
`define STMR_OINIT_BIT  3
`define STMR_POL_BIT    2
`define STMR_SWAP_BIT   1
`define STMR_CLRSEL_BIT 0
// reset values
`define STMR_CTL0_RST   8'h00
`define STMR_CTL1_RST   8'h00
`define STMR_CMPA_RST   10'h000
// prescaler terminal counts (divide by 4, 16, 64)
`define STMR_DIV4_MASK  6'h03
`define STMR_DIV16_MASK 6'h0f
`define STMR_DIV64_MASK 6'h3f
`endif

//--- core/stmr_pkg.sv
package stmr_pkg;
   typedef enum logic [1:0] {
      STMR_COMPARE = 2'h0,
      STMR_CAPTURE = 2'h1,
      STMR_PWM     = 2'h2,
      STMR_TIMER   = 2'h3
   } stmr_mode_type;
   typedef enum logic [2:0] {
      STMR_CK_SYS4  = 3'h0,
      STMR_CK_SYS   = 3'h1,
      STMR_CK_HI16  = 3'h2,
      STMR_CK_HI64  = 3'h3,
      STMR_CK_TBASE = 3'h4,
      STMR_CK_RSVD  = 3'h5,
      STMR_CK_EXTR  = 3'h6,
      STMR_CK_EXTF  = 3'h7
   } stmr_clksel_type;
   typedef struct packed {
      logic [9:0]  count;
      logic [9:0]  cmpA;
      logic [7:0]  ctl0;
      logic [7:0]  ctl1;
      logic        onPrev;
      logic [5:0]  presc;
      logic [2:0]  extSync;
      logic        outLevel;
      logic        pinOut;
      logic        pFlag;
      logic        aFlag;
      logic        ack;
      logic [31:0] rdData;
   } stmr_state_type;
endpackage : stmr_pkg

//--- core/stmr_core.sv
// The implementer's own choices: register access over Wishbone and the placing of the registers.
`timescale 1ns/100ps
`include "stmr_cfg.svh"
module stmr_core
   import stmr_pkg::*;
#(
   parameter int CNT_WIDTH = 10
)(
   input  wire logic        mclk,
   input  wire logic        rst,
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [7:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic      [31:0] wb_dat_o,
   output logic             wb_ack_o,
   input  wire logic        timebaseTick,
   input  wire logic        externalCountInput,
   output logic             timerOutputPin,
   output logic             periodMatchIrq,
   output logic             compareAMatchIrq
);

   // the comparators and register layout are fixed at ten bits
   if (CNT_WIDTH != 10) begin : g_chk
      $error("stmr_core supports only a 10-bit counter");
   end

   stmr_state_type  s_reg;
   stmr_state_type  s_next;

   // address match, shared by the write and read decoders
   function automatic logic hitReg(input logic [7:0] adr, input logic [7:0] ofs);
      hitReg = (adr == ofs);
   endfunction : hitReg

   logic            timerOn;
   logic            paused;
   stmr_clksel_type clkSel;
   stmr_mode_type   mode;
   logic [2:0]      perField;
   logic [1:0]      oFunc;
   logic            oInit;
   logic            oPol;
   logic            swap;
   logic            clrSel;
   logic            onRise;
   logic            clkEv;
   logic            tick;
   logic [9:0]      cntInc;
   logic            pHit;
   logic            aHit;
   logic            clrByA;
   logic            doClear;
   logic [9:0]      duty;
   logic            pwmLevel;
   logic            busReq;
   logic            wrLow;

   // field views of the control registers
   assign timerOn  = s_reg.ctl0[`STMR_ON_BIT];
   assign paused   = s_reg.ctl0[`STMR_PAUSE_BIT];
   assign clkSel   = stmr_clksel_type'(s_reg.ctl0[`STMR_CKSEL_HI:`STMR_CKSEL_LO]);
   assign perField = s_reg.ctl0[`STMR_PER_HI:`STMR_PER_LO];
   assign mode     = stmr_mode_type'(s_reg.ctl1[`STMR_MODE_HI:`STMR_MODE_LO]);
   assign oFunc    = s_reg.ctl1[`STMR_OFUNC_HI:`STMR_OFUNC_LO];
   assign oInit    = s_reg.ctl1[`STMR_OINIT_BIT];
   assign oPol     = s_reg.ctl1[`STMR_POL_BIT];
   assign swap     = s_reg.ctl1[`STMR_SWAP_BIT];
   assign clrSel   = s_reg.ctl1[`STMR_CLRSEL_BIT];
   assign onRise   = timerOn & ~s_reg.onPrev;

   // count-clock selection; high clock is taken as mclk here
   always_comb begin
      case (clkSel)
         STMR_CK_SYS4:  clkEv = ((s_reg.presc & `STMR_DIV4_MASK) == `STMR_DIV4_MASK);
         STMR_CK_SYS:   clkEv = 1'b1;
         STMR_CK_HI16:  clkEv = ((s_reg.presc & `STMR_DIV16_MASK) == `STMR_DIV16_MASK);
         STMR_CK_HI64:  clkEv = (s_reg.presc == `STMR_DIV64_MASK);
         STMR_CK_TBASE: clkEv = timebaseTick;
         STMR_CK_EXTR:  clkEv = s_reg.extSync[1] & ~s_reg.extSync[2];
         STMR_CK_EXTF:  clkEv = ~s_reg.extSync[1] & s_reg.extSync[2];
         default:       clkEv = 1'b0; // reserved code: no clock
      endcase
   end

   // counting and comparison
   assign tick   = timerOn & ~paused & clkEv & ~onRise;
   assign cntInc = s_reg.count + 10'h001;
   // period match when counter reaches n*128; code 0 is left to overflow
   assign pHit   = tick && (cntInc[9:7] == perField) && (cntInc[6:0] == 7'h00)
                   && (perField != 3'h0);
   assign aHit   = tick && (cntInc == s_reg.cmpA) && (s_reg.cmpA != 10'h000);
   // pwm uses the swap bit; other modes use the clear-source bit
   assign clrByA  = (mode == STMR_PWM) ? swap : clrSel;
   assign doClear = clrByA ? aHit : pHit;

   // pwm duty comes from whichever register does not set the period
   assign duty     = swap ? {perField, 7'h00} : s_reg.cmpA;
   assign pwmLevel = (s_reg.count < duty) ? oInit : ~oInit;

   assign busReq = wb_cyc_i & wb_stb_i & ~s_reg.ack;
   assign wrLow  = busReq & wb_we_i & wb_sel_i[0];

   // next-state logic for the whole block
   always_comb begin
      s_next = s_reg;
      s_next.presc   = s_reg.presc + 6'h01;
      s_next.extSync = {s_reg.extSync[1:0], externalCountInput};
      s_next.onPrev  = timerOn;
      // counter: software can only clear it via the on bit
      if (onRise) begin
         s_next.count = 10'h000;
      end else if (tick) begin
         s_next.count = doClear ? 10'h000 : cntInc; // wraps at 3ff
      end
      // interrupt request pulses; no period flag when clear-select picks compare-A outside pwm
      s_next.pFlag = pHit & ~(clrSel & (mode != STMR_PWM));
      s_next.aFlag = aHit;
      // compare-mode output latch
      if (onRise) begin
         s_next.outLevel = oInit;
      end else if (aHit) begin
         case (oFunc)
            2'h1:    s_next.outLevel = 1'b0;
            2'h2:    s_next.outLevel = 1'b1;
            2'h3:    s_next.outLevel = ~s_reg.outLevel;
            default: s_next.outLevel = s_reg.outLevel;
         endcase
      end
      // pin drive per mode; pwm keeps running while forced
      case (mode)
         STMR_COMPARE: s_next.pinOut = s_next.outLevel ^ oPol;
         STMR_PWM: begin
            case (oFunc)
               2'h1:    s_next.pinOut = oInit ^ oPol;
               2'h2:    s_next.pinOut = pwmLevel ^ oPol;
               default: s_next.pinOut = ~oInit ^ oPol;
            endcase
         end
         default: s_next.pinOut = 1'b0; // pin unused in timer/capture
      endcase
      // wishbone writes; counter pair is read-only
      if (wrLow) begin
         if (hitReg(wb_adr_i, `STMR_OFS_CTL0)) begin
            s_next.ctl0 = wb_dat_i[7:0];
         end
         if (hitReg(wb_adr_i, `STMR_OFS_CTL1)) begin
            s_next.ctl1 = wb_dat_i[7:0];
         end
         if (hitReg(wb_adr_i, `STMR_OFS_CMPAL)) begin
            s_next.cmpA[7:0] = wb_dat_i[7:0];
         end
         if (hitReg(wb_adr_i, `STMR_OFS_CMPAH)) begin
            s_next.cmpA[9:8] = wb_dat_i[1:0];
         end
      end
      // one-cycle ack; unmapped addresses answer with zero
      s_next.ack    = busReq;
      s_next.rdData = 32'h0000_0000;
      if (busReq & ~wb_we_i) begin
         if (hitReg(wb_adr_i, `STMR_OFS_CTL0)) begin
            s_next.rdData = {24'h000000, s_reg.ctl0};
         end
         if (hitReg(wb_adr_i, `STMR_OFS_CTL1)) begin
            s_next.rdData = {24'h000000, s_reg.ctl1};
         end
         if (hitReg(wb_adr_i, `STMR_OFS_CNTL)) begin
            s_next.rdData = {24'h000000, s_reg.count[7:0]};
         end
         if (hitReg(wb_adr_i, `STMR_OFS_CNTH)) begin
            s_next.rdData = {30'h0, s_reg.count[9:8]};
         end
         if (hitReg(wb_adr_i, `STMR_OFS_CMPAL)) begin
            s_next.rdData = {24'h000000, s_reg.cmpA[7:0]};
         end
         if (hitReg(wb_adr_i, `STMR_OFS_CMPAH)) begin
            s_next.rdData = {30'h0, s_reg.cmpA[9:8]};
         end
      end
   end

   // state register; power-on clears everything
   always_ff @(posedge mclk) begin
      if (rst) begin
         s_reg         <= '0;
         s_reg.ctl0    <= `STMR_CTL0_RST;
         s_reg.ctl1    <= `STMR_CTL1_RST;
         s_reg.cmpA    <= `STMR_CMPA_RST;
      end else begin
         s_reg <= s_next;
      end
   end

   // outputs straight from the state flops
   assign wb_dat_o         = s_reg.rdData;
   assign wb_ack_o         = s_reg.ack;
   assign timerOutputPin   = s_reg.pinOut;
   assign periodMatchIrq   = s_reg.pFlag;
   assign compareAMatchIrq = s_reg.aFlag;

   // checks
   sequence sq_onRise;
      onRise;
   endsequence
   sequence sq_cntZero;
      s_reg.count == 10'h000;
   endsequence

   property p_onClear;
      @(posedge mclk) disable iff (rst) sq_onRise |=> sq_cntZero;
   endproperty
   a_onClear: assert property (p_onClear) else $error("on edge did not zero counter");

   property p_pauseHold;
      @(posedge mclk) disable iff (rst) (paused & ~onRise) |=> $stable(s_reg.count);
   endproperty
   a_pauseHold: assert property (p_pauseHold) else $error("counter moved while paused");

   property p_offHold;
      @(posedge mclk) disable iff (rst) ~timerOn |=> $stable(s_reg.count);
   endproperty
   a_offHold: assert property (p_offHold) else $error("counter moved while off");

   property p_rsvdHold;
      @(posedge mclk) disable iff (rst)
         (clkSel == STMR_CK_RSVD && !onRise) |=> $stable(s_reg.count);
   endproperty
   a_rsvdHold: assert property (p_rsvdHold) else $error("reserved clock still counts");

   property p_sysAdvance;
      @(posedge mclk) disable iff (rst)
         (clkSel == STMR_CK_SYS && timerOn && !paused && !onRise && !doClear)
         |=> s_reg.count == $past(s_reg.count) + 10'h001;
   endproperty
   a_sysAdvance: assert property (p_sysAdvance) else $error("counter did not advance");

   property p_perClear;
      @(posedge mclk) disable iff (rst) (pHit && !clrByA && !onRise) |=> sq_cntZero;
   endproperty
   a_perClear: assert property (p_perClear) else $error("period match did not clear");

   property p_swapClear;
      @(posedge mclk) disable iff (rst)
         (mode == STMR_PWM && swap && aHit) |=> (s_reg.count == 10'h000) && compareAMatchIrq;
   endproperty
   a_swapClear: assert property (p_swapClear) else $error("pwm swap clear wrong");

   property p_initLevel;
      @(posedge mclk) disable iff (rst)
         (mode == STMR_COMPARE && onRise) |=> timerOutputPin == ($past(oInit) ^ $past(oPol));
   endproperty
   a_initLevel: assert property (p_initLevel) else $error("output not at initial level");

   property p_cmpHigh;
      @(posedge mclk) disable iff (rst)
         (mode == STMR_COMPARE && aHit && oFunc == 2'h2 && !onRise)
         |=> compareAMatchIrq && timerOutputPin == ~$past(oPol);
   endproperty
   a_cmpHigh: assert property (p_cmpHigh) else $error("compare output not high");

   property p_ackPulse;
      @(posedge mclk) disable iff (rst) busReq |=> wb_ack_o ##1 !wb_ack_o;
   endproperty
   a_ackPulse: assert property (p_ackPulse) else $error("bus ack not a single pulse");

   property p_aClear;
      @(posedge mclk) disable iff (rst) (mode != STMR_PWM && clrSel && aHit) |=> sq_cntZero;
   endproperty
   a_aClear: assert property (p_aClear) else $error("compare-A match did not clear");

   property p_aIrq;
      @(posedge mclk) disable iff (rst) aHit |=> compareAMatchIrq;
   endproperty
   a_aIrq: assert property (p_aIrq) else $error("compare-A request missing");

   property p_perIrq;
      @(posedge mclk) disable iff (rst) (pHit && !(clrSel && mode != STMR_PWM)) |=> periodMatchIrq;
   endproperty
   a_perIrq: assert property (p_perIrq) else $error("period request missing");

   property p_noTickHold;
      @(posedge mclk) disable iff (rst) (!tick && !onRise) |=> $stable(s_reg.count);
   endproperty
   a_noTickHold: assert property (p_noTickHold) else $error("counter moved without an event");

   // pin edges and time-base ticks each add exactly one count
   property p_extRise;
      @(posedge mclk) disable iff (rst)
         (clkSel == STMR_CK_EXTR && timerOn && !paused && !onRise && !doClear
          && s_reg.extSync[1] && !s_reg.extSync[2]) |=> s_reg.count == $past(s_reg.count) + 10'h001;
   endproperty
   a_extRise: assert property (p_extRise) else $error("rising pin edge not counted");

   property p_extFall;
      @(posedge mclk) disable iff (rst)
         (clkSel == STMR_CK_EXTF && timerOn && !paused && !onRise && !doClear
          && !s_reg.extSync[1] && s_reg.extSync[2]) |=> s_reg.count == $past(s_reg.count) + 10'h001;
   endproperty
   a_extFall: assert property (p_extFall) else $error("falling pin edge not counted");

   property p_tbaseTick;
      @(posedge mclk) disable iff (rst)
         (clkSel == STMR_CK_TBASE && timerOn && !paused && !onRise && !doClear && timebaseTick)
         |=> s_reg.count == $past(s_reg.count) + 10'h001;
   endproperty
   a_tbaseTick: assert property (p_tbaseTick) else $error("time-base tick not counted");

   // forced pwm levels follow the active-level bit while the counter runs on
   property p_pwmInactive;
      @(posedge mclk) disable iff (rst)
         (mode == STMR_PWM && oFunc == 2'h0) |=> timerOutputPin == (~$past(oInit) ^ $past(oPol));
   endproperty
   a_pwmInactive: assert property (p_pwmInactive) else $error("forced inactive level wrong");

   property p_pwmActive;
      @(posedge mclk) disable iff (rst)
         (mode == STMR_PWM && oFunc == 2'h1) |=> timerOutputPin == ($past(oInit) ^ $past(oPol));
   endproperty
   a_pwmActive: assert property (p_pwmActive) else $error("forced active level wrong");

endmodule : stmr_core

//--- tb/tb_stmr_core.sv
`timescale 1ns/100ps
`include "stmr_cfg.svh"
module tb_stmr_core;
   import stmr_pkg::*;
   logic        mclk = 1'b0;
   logic        rst  = 1'b1;
   logic        wbCyc = 1'b0, wbStb = 1'b0, wbWe = 1'b0;
   logic [7:0]  wbAdr = 8'h00;
   logic [3:0]  wbSel = 4'h0;
   logic [31:0] wbDatI = 32'h0, wbDatO, rd;
   logic        wbAck, tbTick = 1'b0, extIn = 1'b0, pinOut, pIrq, aIrq;
   int          nMismatch = 0, totalChecks = 0, per, highs;
   stmr_core i_dut (.mclk(mclk), .rst(rst), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb), .wb_we_i(wbWe),
      .wb_adr_i(wbAdr), .wb_sel_i(wbSel), .wb_dat_i(wbDatI), .wb_dat_o(wbDatO), .wb_ack_o(wbAck),
      .timebaseTick(tbTick), .externalCountInput(extIn), .timerOutputPin(pinOut),
      .periodMatchIrq(pIrq), .compareAMatchIrq(aIrq));
   // free-running 100 MHz clock
   always #5 mclk = ~mclk;
   task summarize;
      $display("checks %0d mismatches %0d", totalChecks, nMismatch);
      if (nMismatch == 0 && totalChecks > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask : summarize
   task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      totalChecks++;
      if (got !== exp) begin
         nMismatch++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk
   // one classic cycle; request held until ack is sampled high
   task xfer(input logic we, input logic [7:0] a, input logic [7:0] d, output logic [31:0] q);
      int n;
      n = 0;
      @(posedge mclk);
      wbCyc <= 1'b1; wbStb <= 1'b1; wbWe <= we; wbAdr <= a; wbSel <= 4'hf; wbDatI <= {24'h0, d};
      do begin
         @(posedge mclk);
         n++;
      end while (wbAck !== 1'b1 && n < 50);
      if (n >= 50) chk("ack", 1'b1, wbAck);
      q = wbDatO;
      wbCyc <= 1'b0; wbStb <= 1'b0; wbWe <= 1'b0;
   endtask : xfer
   task wr(input logic [7:0] a, input logic [7:0] d);
      logic [31:0] q;
      xfer(1'b1, a, d, q);
   endtask : wr
   task rdreg(input logic [7:0] a, output logic [31:0] q);
      xfer(1'b0, a, 8'h00, q);
   endtask : rdreg
   // cycles between two irq pulses, and pin-high cycles within that window
   task measure(input bit useA);
      int n;
      n = 0; per = 0; highs = 0;
      do begin
         @(posedge mclk);
         n++;
      end while ((useA ? aIrq : pIrq) !== 1'b1 && n < 3000);
      do begin
         @(posedge mclk);
         per++;
         if (pinOut === 1'b1) highs++;
      end while ((useA ? aIrq : pIrq) !== 1'b1 && per < 3000);
   endtask : measure
   // pulses on the pin or the time-base tick, spaced well past the synchroniser
   task pulses(input bit onTick, input int k);
      repeat (k) begin
         @(posedge mclk);
         if (onTick) tbTick <= 1'b1; else extIn <= 1'b1;
         @(posedge mclk);
         tbTick <= 1'b0;
         repeat (7) @(posedge mclk);
         extIn <= 1'b0;
         repeat (8) @(posedge mclk);
      end
   endtask : pulses
   task t_regs;
      rdreg(`STMR_OFS_CTL0, rd); chk("ctl0 reset", 32'h0, rd);
      rdreg(`STMR_OFS_CMPAH, rd); chk("cmpah reset", 32'h0, rd);
      rdreg(8'h18, rd); chk("unmapped", 32'h0, rd);
      wr(`STMR_OFS_CTL1, 8'ha5); rdreg(`STMR_OFS_CTL1, rd); chk("ctl1", 32'ha5, rd);
      wr(`STMR_OFS_CMPAL, 8'hab); wr(`STMR_OFS_CMPAH, 8'hff);
      rdreg(`STMR_OFS_CMPAL, rd); chk("cmpal", 32'hab, rd);
      rdreg(`STMR_OFS_CMPAH, rd); chk("cmpah", 32'h03, rd);
      wr(`STMR_OFS_CNTL, 8'h55); rdreg(`STMR_OFS_CNTL, rd); chk("cnt ro", 32'h0, rd);
      wr(`STMR_OFS_CTL1, 8'h00);
   endtask : t_regs
   task t_count;
      logic [31:0] a;
      wr(`STMR_OFS_CTL0, 8'h18); repeat (20) @(posedge mclk);
      wr(`STMR_OFS_CTL0, 8'h98); rdreg(`STMR_OFS_CNTL, a); rdreg(`STMR_OFS_CNTL, rd);
      chk("paused hold", a, rd);
      wr(`STMR_OFS_CTL0, 8'h18); rdreg(`STMR_OFS_CNTL, rd);
      chk("resume", 1'b1, rd > a);
      wr(`STMR_OFS_CTL0, 8'h10); rdreg(`STMR_OFS_CNTL, a); repeat (10) @(posedge mclk);
      rdreg(`STMR_OFS_CNTL, rd); chk("off hold", a, rd);
      wr(`STMR_OFS_CTL0, 8'h18); rdreg(`STMR_OFS_CNTL, rd);
      chk("on clears", 1'b1, rd < 8 && rd < a);
      wr(`STMR_OFS_CTL0, 8'h10); wr(`STMR_OFS_CTL0, 8'h58); repeat (10) @(posedge mclk);
      rdreg(`STMR_OFS_CNTL, rd); chk("reserved clk", 32'h0, rd);
   endtask : t_count
   task t_sources;
      wr(`STMR_OFS_CTL0, 8'h00); wr(`STMR_OFS_CTL0, 8'h68); pulses(1'b0, 5);
      rdreg(`STMR_OFS_CNTL, rd); chk("ext rise", 32'h5, rd);
      wr(`STMR_OFS_CTL0, 8'h00); wr(`STMR_OFS_CTL0, 8'h78); pulses(1'b0, 3);
      rdreg(`STMR_OFS_CNTL, rd); chk("ext fall", 32'h3, rd);
      wr(`STMR_OFS_CTL0, 8'h00); wr(`STMR_OFS_CTL0, 8'h48); pulses(1'b1, 4);
      rdreg(`STMR_OFS_CNTL, rd); chk("timebase", 32'h4, rd);
   endtask : t_sources
   // compare-A clears after ten ticks, so each period shows one prescaler ratio
   task t_divide;
      wr(`STMR_OFS_CTL0, 8'h00); wr(`STMR_OFS_CMPAL, 8'h0a); wr(`STMR_OFS_CMPAH, 8'h00);
      wr(`STMR_OFS_CTL1, 8'h01); wr(`STMR_OFS_CTL0, 8'h08); measure(1'b1);
      chk("sys div4", 32'd40, per);
      wr(`STMR_OFS_CTL0, 8'h00); wr(`STMR_OFS_CTL0, 8'h28); measure(1'b1);
      chk("high div16", 32'd160, per);
      wr(`STMR_OFS_CTL0, 8'h00); wr(`STMR_OFS_CTL0, 8'h38); measure(1'b1);
      chk("high div64", 32'd640, per);
      wr(`STMR_OFS_CTL0, 8'h00); wr(`STMR_OFS_CTL1, 8'h00);
   endtask : t_divide
   task t_period;
      wr(`STMR_OFS_CTL0, 8'h00); wr(`STMR_OFS_CTL0, 8'h19); measure(1'b0);
      chk("period 1", 32'd128, per);
      wr(`STMR_OFS_CTL0, 8'h00); wr(`STMR_OFS_CTL0, 8'h1b); measure(1'b0);
      chk("period 3", 32'd384, per);
   endtask : t_period
   task t_cmpout;
      wr(`STMR_OFS_CTL0, 8'h00); wr(`STMR_OFS_CMPAL, 8'h64); wr(`STMR_OFS_CMPAH, 8'h00);
      wr(`STMR_OFS_CTL1, 8'h20); wr(`STMR_OFS_CTL0, 8'h18); measure(1'b1);
      chk("pin set", 1'b1, pinOut);
      wr(`STMR_OFS_CTL0, 8'h10); wr(`STMR_OFS_CTL0, 8'h18); repeat (2) @(posedge mclk);
      chk("pin initial", 1'b0, pinOut);
   endtask : t_cmpout
   task t_pwm;
      // swap set: compare-A sets the period, period field the duty; clear-select is ignored in pwm, so only swap picks A
      wr(`STMR_OFS_CTL0, 8'h00); wr(`STMR_OFS_CMPAL, 8'hc8); wr(`STMR_OFS_CTL1, 8'haa);
      wr(`STMR_OFS_CTL0, 8'h19); measure(1'b1);
      chk("pwm period", 32'd200, per);
      chk("pwm duty", 32'd128, highs);
      wr(`STMR_OFS_CTL1, 8'h8b); measure(1'b1);
      chk("forced period", 32'd200, per);
      chk("forced level", 32'd0, highs);
      wr(`STMR_OFS_CTL1, 8'h9b); measure(1'b1);
      chk("active period", 32'd200, per);
      chk("active level", 32'd200, highs);
   endtask : t_pwm
   // a hang cuts the run short through the same closing task
   initial begin
      repeat (40000) @(posedge mclk);
      nMismatch++;
      summarize;
   end
   initial begin
      repeat (4) @(posedge mclk);
      rst <= 1'b0;
      t_regs;
      t_count;
      t_sources;
      t_divide;
      t_period;
      t_cmpout;
      t_pwm;
      summarize;
   end
endmodule : tb_stmr_core
